//--- stpu_pkg.sv
package stpu_pkg;
    localparam int NUM_TRAPS = 16;
    localparam int AXI_AW = 8;

    // register byte offsets
    localparam logic [7:0] OFS_TBR = 8'h00;
    localparam logic [7:0] OFS_CWP = 8'h04;
    localparam logic [7:0] OFS_WIM = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0C;
    localparam logic [7:0] OFS_WATCH = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // field positions
    localparam int TBR_BASE_LSB = 12;
    localparam int TRAP_TYPE_FIELD_LSB = 4;
    localparam int CTRL_SUP_BIT = 0;
    localparam int CTRL_FPEN_BIT = 1;
    localparam int CTRL_TEM_LSB = 8;
    localparam int WATCH_IEN_BIT = 0;
    localparam int WATCH_DEN_BIT = 1;
    localparam int STAT_FTT_LSB = 0;
    localparam int STAT_LAST_LSB = 8;
    localparam int STAT_WPEND_BIT = 16;

    // reset values
    localparam logic [19:0] TBR_BASE_RST = 20'h00000;
    localparam logic [7:0] TT_RST = 8'h00;
    localparam logic [2:0] CWP_RST = 3'h0;
    localparam logic [7:0] WIM_RST = 8'h00;
    localparam logic [31:0] RESET_PC = 32'h00000000;
    localparam logic [31:0] PC_STEP = 32'h00000004;

    // trap type codes
    localparam logic [7:0] TT_WRITE_ERR = 8'h2B;
    localparam logic [7:0] TT_INST_ACC = 8'h01;
    localparam logic [7:0] TT_ILLEGAL = 8'h02;
    localparam logic [7:0] TT_PRIV = 8'h03;
    localparam logic [7:0] TT_FP_DIS = 8'h04;
    localparam logic [7:0] TT_CP_DIS = 8'h24;
    localparam logic [7:0] TT_WATCH = 8'h0B;
    localparam logic [7:0] TT_WIN_OVF = 8'h05;
    localparam logic [7:0] TT_WIN_UNF = 8'h06;
    localparam logic [7:0] TT_REG_HW = 8'h20;
    localparam logic [7:0] TT_ALIGN = 8'h07;
    localparam logic [7:0] TT_FP_EXC = 8'h08;
    localparam logic [7:0] TT_DATA_ACC = 8'h09;
    localparam logic [7:0] TT_TAG_OVF = 8'h0A;
    localparam logic [7:0] TT_DIV_ZERO = 8'h2A;
    localparam logic [7:0] TT_SW_BASE = 8'h80;

    // request index, 0 is the highest priority after reset
    localparam logic [3:0] IX_WRITE_ERR = 4'h0;
    localparam logic [3:0] IX_FP_EXC = 4'hB;

    // fpu cause codes
    localparam logic [2:0] FTT_NONE = 3'h0;
    localparam logic [2:0] FTT_IEEE = 3'h1;
    localparam logic [2:0] FTT_UNFINISHED = 3'h2;
    localparam logic [2:0] FTT_UNIMP = 3'h3;
    localparam logic [2:0] FTT_SEQ = 3'h4;
    localparam logic [2:0] FTT_HW = 3'h5;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum {STPU_RESET_ENTRY, STPU_RUN} stpu_state_t;
endpackage

//--- stpu_sel_if.sv
`timescale 1ns/100ps
interface stpu_sel_if;
    import stpu_pkg::*;
    logic [NUM_TRAPS-1:0] req;
    logic any;
    logic [3:0] idx;
    modport sel (input req, output any, output idx);
    modport user (output req, input any, input idx);
endinterface

//--- stpu_prio_sel.sv
`timescale 1ns/100ps
module stpu_prio_sel
    import stpu_pkg::*;
(
    stpu_sel_if.sel s
);
    // lowest index wins, all others are dropped
    always_comb begin
        s.idx = 4'h0;
        for (int i = NUM_TRAPS - 1; i >= 0; i--) begin
            if (s.req[i]) begin
                s.idx = 4'(i);
            end
        end
    end

    assign s.any = |s.req;
endmodule // stpu_prio_sel

//--- stpu_trap_unit.sv
// Notes on behaviour
// - sync traps within instruction, async only between
// - vector through table base by trap type
// - advance window, save pc and npc there
// - take only highest priority simultaneous trap
// - reset trap first, right after reset release
// - reset trap leaves trap type field unchanged
// - write buffer error gives 0x2B, priority 2
// - fetch error gives 0x01, priority 3
// - illegal opcode gives 0x02, priority 5
// - privileged op in user gives 0x03
// - fp op with fpu disabled gives 0x04
// - any coprocessor op gives 0x24
// - watchpoint address match gives 0x0B
// - save into invalid window gives 0x05
// - restore into invalid window gives 0x06
// - register file uncorrectable error gives 0x20
// - misaligned address or target gives 0x07
// - fpu faults give 0x08, record cause
// - data access error gives 0x09
// - tagged overflow or tag bits give 0x0A
// - divide by zero 0x2A, ticc 0x80-0xFF
// - diagnostic access during flush blocked, 0x09
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module stpu_trap_unit
    import stpu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    // axi4-lite slave
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pipeline condition inputs
    input wire logic inst_valid,
    input wire logic [31:0] inst_pc,
    input wire logic [31:0] inst_npc,
    input wire logic write_buffer_err,
    input wire logic fetch_err,
    input wire logic illegal_op,
    input wire logic priv_op,
    input wire logic fp_op,
    input wire logic cp_op,
    input wire logic [31:0] fetch_addr,
    input wire logic data_access,
    input wire logic [31:0] data_addr,
    input wire logic save_op,
    input wire logic restore_op,
    input wire logic regfile_err,
    input wire logic misaligned,
    input wire logic [4:0] fpu_ieee_exc,
    input wire logic fpu_unimp,
    input wire logic fpu_unfinished,
    input wire logic fpu_seq_err,
    input wire logic fpu_hw_err,
    input wire logic data_err,
    input wire logic tag_ovf,
    input wire logic div_zero,
    input wire logic ticc_true,
    input wire logic [6:0] ticc_num,
    input wire logic diag_cache_access,
    input wire logic cache_flush_busy,
    // trap outputs
    output logic trap_annul,
    output logic diag_access_block,
    output logic trap_taken,
    output logic trap_is_reset,
    output logic [7:0] trap_type,
    output logic [31:0] trap_target_pc,
    output logic [31:0] trap_target_npc,
    output logic win_save_we,
    output logic [2:0] win_save_idx,
    output logic [31:0] win_save_pc,
    output logic [31:0] win_save_npc,
    output logic supervisor_bit,
    output logic [2:0] current_window_pointer
);
    stpu_sel_if sel_bus ();

    stpu_prio_sel u_sel (
        .s(sel_bus.sel)
    );

    stpu_state_t state_reg;
    logic [19:0] tbr_base_reg;
    logic [7:0] trap_type_field;
    logic [2:0] cwp_reg;
    logic [7:0] window_invalid_mask;
    logic sup_reg;
    logic fpu_en_reg;
    logic [4:0] fpu_trap_enable_mask;
    logic [29:0] watch_addr_reg;
    logic watch_ien_reg;
    logic watch_den_reg;
    logic [2:0] fpu_trap_cause;
    logic [7:0] last_tt_reg;
    logic wr_err_pend_reg;

    logic [2:0] cwp_dec;
    logic [2:0] cwp_inc;
    logic watch_hit;
    logic fpu_fault;
    logic [2:0] ftt_next;
    logic [7:0] tt_sel;
    logic take;
    logic [31:0] vector;

    assign cwp_dec = cwp_reg - 3'h1;
    assign cwp_inc = cwp_reg + 3'h1;
    assign watch_hit = (watch_ien_reg && fetch_addr[31:2] == watch_addr_reg)
        || (watch_den_reg && data_access
        && data_addr[31:2] == watch_addr_reg);
    assign fpu_fault = (|(fpu_ieee_exc & fpu_trap_enable_mask)) || fpu_unimp
        || fpu_unfinished || fpu_seq_err || fpu_hw_err;
    assign ftt_next = (|(fpu_ieee_exc & fpu_trap_enable_mask)) ? FTT_IEEE
        : fpu_unimp ? FTT_UNIMP : fpu_unfinished ? FTT_UNFINISHED
        : fpu_seq_err ? FTT_SEQ : fpu_hw_err ? FTT_HW : FTT_NONE;

    // only an instruction in flight can be trapped
    logic gate;
    assign gate = inst_valid && (state_reg == STPU_RUN);

    always_comb begin
        sel_bus.req = '0;
        sel_bus.req[0] = wr_err_pend_reg || write_buffer_err;
        sel_bus.req[1] = fetch_err;
        sel_bus.req[2] = priv_op && !sup_reg;
        sel_bus.req[3] = illegal_op;
        sel_bus.req[4] = fp_op && !fpu_en_reg;
        sel_bus.req[5] = cp_op;
        sel_bus.req[6] = watch_hit;
        sel_bus.req[7] = save_op && window_invalid_mask[cwp_dec];
        sel_bus.req[8] = restore_op && window_invalid_mask[cwp_inc];
        sel_bus.req[9] = regfile_err;
        sel_bus.req[10] = misaligned;
        sel_bus.req[11] = fp_op && fpu_en_reg && fpu_fault;
        sel_bus.req[12] = data_err || diag_access_block;
        sel_bus.req[13] = tag_ovf;
        sel_bus.req[14] = div_zero;
        sel_bus.req[15] = ticc_true;
        if (!gate) begin
            sel_bus.req = '0;
        end
    end

    logic [7:0] tt_tab [NUM_TRAPS];
    assign tt_tab = '{TT_WRITE_ERR, TT_INST_ACC, TT_PRIV, TT_ILLEGAL,
        TT_FP_DIS, TT_CP_DIS, TT_WATCH, TT_WIN_OVF, TT_WIN_UNF, TT_REG_HW,
        TT_ALIGN, TT_FP_EXC, TT_DATA_ACC, TT_TAG_OVF, TT_DIV_ZERO,
        TT_SW_BASE | {1'b0, ticc_num}};
    assign tt_sel = tt_tab[sel_bus.idx];

    assign take = sel_bus.any;
    assign vector = {tbr_base_reg, tt_sel, 4'h0};
    assign trap_annul = take;
    // the access itself must never reach the cache arrays
    assign diag_access_block = diag_cache_access && cache_flush_busy;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= STPU_RESET_ENTRY;
        end else begin
            state_reg <= STPU_RUN;
        end
    end

    // a late buffered store error waits for the next instruction
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_err_pend_reg <= 1'b0;
        end else if (take && sel_bus.idx == IX_WRITE_ERR) begin
            wr_err_pend_reg <= 1'b0;
        end else if (write_buffer_err) begin
            wr_err_pend_reg <= 1'b1;
        end
    end

    // trap entry outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trap_taken <= 1'b0;
            trap_is_reset <= 1'b0;
            trap_type <= TT_RST;
            trap_target_pc <= RESET_PC;
            trap_target_npc <= RESET_PC;
            win_save_we <= 1'b0;
            win_save_idx <= CWP_RST;
            win_save_pc <= RESET_PC;
            win_save_npc <= RESET_PC;
        end else begin
            trap_taken <= take || state_reg == STPU_RESET_ENTRY;
            trap_is_reset <= state_reg == STPU_RESET_ENTRY;
            win_save_we <= take;
            if (state_reg == STPU_RESET_ENTRY) begin
                trap_target_pc <= RESET_PC;
                trap_target_npc <= RESET_PC + PC_STEP;
            end else if (take) begin
                trap_type <= tt_sel;
                trap_target_pc <= vector;
                trap_target_npc <= vector + PC_STEP;
                win_save_idx <= cwp_dec;
                win_save_pc <= inst_pc;
                win_save_npc <= inst_npc;
            end
        end
    end

    // register bus
    logic aw_held_reg;
    logic w_held_reg;
    logic [AXI_AW-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_wr;
    logic [31:0] cur_word;
    logic [31:0] new_word;
    logic [31:0] lane_mask;
    logic wr_mapped;
    logic rd_mapped;
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_wr = aw_held_reg && w_held_reg && !s_axi_bvalid;
    // tt and status are read-only, so writes decode fewer words
    function automatic logic [31:0] view(input logic [AXI_AW-1:0] a);
        case ({a[AXI_AW-1:2], 2'b00})
            OFS_TBR: view = {tbr_base_reg, trap_type_field, 4'h0};
            OFS_CWP: view = {29'h0, cwp_reg};
            OFS_WIM: view = {24'h0, window_invalid_mask};
            OFS_CTRL: view = {19'h0, fpu_trap_enable_mask, 6'h0,
                fpu_en_reg, sup_reg};
            OFS_WATCH: view = {watch_addr_reg, watch_den_reg,
                watch_ien_reg};
            OFS_STATUS: view = {15'h0, wr_err_pend_reg, last_tt_reg,
                5'h0, fpu_trap_cause};
            default: view = 32'h0;
        endcase
    endfunction

    always_comb cur_word = view(awaddr_reg);
    assign wr_mapped = awaddr_reg <= OFS_WATCH;
    assign rd_mapped = {s_axi_araddr[AXI_AW-1:2], 2'b00} <= OFS_STATUS;
    assign lane_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
        {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    assign new_word = (cur_word & ~lane_mask) | (wdata_reg & lane_mask);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_held_reg) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= {s_axi_awaddr[AXI_AW-1:2], 2'b00};
            end else if (do_wr) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && !w_held_reg) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (do_wr) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // software-visible state; trap entry overrides a same-cycle write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tbr_base_reg <= TBR_BASE_RST;
            cwp_reg <= CWP_RST;
            window_invalid_mask <= WIM_RST;
            sup_reg <= 1'b1;
            fpu_en_reg <= 1'b0;
            fpu_trap_enable_mask <= 5'h00;
            watch_addr_reg <= 30'h0;
            watch_ien_reg <= 1'b0;
            watch_den_reg <= 1'b0;
        end else begin
            if (do_wr) begin
                case (awaddr_reg)
                    OFS_TBR: tbr_base_reg <= new_word[31:TBR_BASE_LSB];
                    OFS_CWP: cwp_reg <= new_word[2:0];
                    OFS_WIM: window_invalid_mask <= new_word[7:0];
                    OFS_CTRL: begin
                        sup_reg <= new_word[CTRL_SUP_BIT];
                        fpu_en_reg <= new_word[CTRL_FPEN_BIT];
                        fpu_trap_enable_mask <=
                            new_word[CTRL_TEM_LSB +: 5];
                    end
                    OFS_WATCH: begin
                        watch_addr_reg <= new_word[31:2];
                        watch_ien_reg <= new_word[WATCH_IEN_BIT];
                        watch_den_reg <= new_word[WATCH_DEN_BIT];
                    end
                    default: ;
                endcase
            end
            if (take) begin
                cwp_reg <= cwp_dec;
                sup_reg <= 1'b1;
            end
        end
    end

    // hardware-only fields
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trap_type_field <= TT_RST;
            last_tt_reg <= TT_RST;
            fpu_trap_cause <= FTT_NONE;
        end else if (take) begin
            // reset entry never reaches here: the reset trap leaves tt at its reset value
            trap_type_field <= tt_sel;
            last_tt_reg <= tt_sel;
            if (sel_bus.idx == IX_FP_EXC) begin
                fpu_trap_cause <= ftt_next;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_DECERR;
            s_axi_rdata <= view(s_axi_araddr);
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign supervisor_bit = sup_reg;
    assign current_window_pointer = cwp_reg;
endmodule // stpu_trap_unit

//--- stpu_trap_unit_assertions.sv
`timescale 1ns/100ps
module stpu_trap_unit_assertions
    import stpu_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inst_valid,
    input wire logic [31:0] inst_pc,
    input wire logic [31:0] inst_npc,
    input wire logic fetch_err,
    input wire logic diag_cache_access,
    input wire logic cache_flush_busy,
    input wire logic trap_annul,
    input wire logic diag_access_block,
    input wire logic trap_taken,
    input wire logic trap_is_reset,
    input wire logic [7:0] trap_type,
    input wire logic [31:0] trap_target_pc,
    input wire logic [31:0] trap_target_npc,
    input wire logic win_save_we,
    input wire logic [2:0] win_save_idx,
    input wire logic [31:0] win_save_pc,
    input wire logic [31:0] win_save_npc,
    input wire logic [2:0] current_window_pointer
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire logic trap_ok = trap_taken && !trap_is_reset;

    a_annul_then_taken: assert property (trap_annul |=> trap_ok)
        else $error("selected trap not taken");
    a_annul_needs_inst: assert property (trap_annul |-> inst_valid)
        else $error("trap outside an instruction");
    a_vector_form: assert property (trap_ok |->
        trap_target_pc[11:0] == {trap_type, 4'h0} &&
        trap_target_npc == trap_target_pc + PC_STEP)
        else $error("handler address wrong");
    a_window_advance: assert property (trap_ok |-> win_save_we &&
        win_save_idx == current_window_pointer &&
        current_window_pointer == 3'($past(current_window_pointer) - 3'h1))
        else $error("window not advanced");
    a_save_counters: assert property (trap_ok |->
        win_save_pc == $past(inst_pc) && win_save_npc == $past(inst_npc))
        else $error("saved counters wrong");
    a_reset_entry: assert property (!$past(rst_n, 2) && $past(rst_n) |->
        trap_is_reset && trap_target_pc == RESET_PC && !win_save_we)
        else $error("reset trap missing");
    a_reset_keeps_tt: assert property (trap_is_reset |-> $stable(trap_type))
        else $error("reset trap changed type");
    a_diag_block: assert property (diag_access_block ==
        (diag_cache_access && cache_flush_busy))
        else $error("diagnostic block wrong");
    a_fetch_prio: assert property (inst_valid && fetch_err && trap_annul |=>
        (trap_type == TT_INST_ACC || trap_type == TT_WRITE_ERR))
        else $error("fetch error priority wrong");

    c_reset: cover property (trap_is_reset);
    c_ticc: cover property (trap_ok && trap_type[7]);
    c_write_err: cover property (trap_ok && trap_type == TT_WRITE_ERR);
    c_diag: cover property (trap_annul && diag_access_block);
endmodule // stpu_trap_unit_assertions

bind stpu_trap_unit stpu_trap_unit_assertions chk (.*);

//--- stpu_pipe_model.sv
`timescale 1ns/100ps
module stpu_pipe_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [18:0] cv,
    input wire logic [31:0] pc,
    output logic inst_valid,
    output logic [31:0] inst_pc,
    output logic [31:0] inst_npc,
    output logic [18:0] cond
);
    logic [18:0] hold_reg;
    logic [1:0] wait_reg;
    logic pend_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {pend_reg, inst_valid, cond, inst_pc, inst_npc} <= '0;
        end else begin
            inst_valid <= 1'b0;
            cond <= 19'($urandom);
            if (go) begin
                pend_reg <= 1'b1;
                hold_reg <= cv;
                wait_reg <= 2'($urandom);
            end else if (pend_reg && wait_reg != 2'h0) begin
                wait_reg <= wait_reg - 2'h1;
            end else if (pend_reg) begin
                pend_reg <= 1'b0;
                inst_valid <= 1'b1;
                inst_pc <= pc;
                inst_npc <= pc + 32'h4;
                cond <= hold_reg;
            end
        end
    end
endmodule // stpu_pipe_model

//--- stpu_trap_unit_test.sv
`timescale 1ns/100ps
module stpu_trap_unit_test;
    import stpu_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, inst_pc, inst_npc, fetch_addr;
    logic [31:0] data_addr, pc, trap_target_pc, trap_target_npc;
    logic [31:0] win_save_pc, win_save_npc;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, inst_valid, write_buffer_err;
    logic fetch_err, illegal_op, priv_op, fp_op, cp_op, save_op;
    logic restore_op, regfile_err, misaligned, fpu_unimp, fpu_unfinished;
    logic fpu_seq_err, fpu_hw_err, data_err, tag_ovf, div_zero, ticc_true;
    logic diag_cache_access, cache_flush_busy, data_access, go;
    logic trap_annul, diag_access_block, trap_taken, trap_is_reset;
    logic win_save_we, supervisor_bit;
    logic [4:0] fpu_ieee_exc;
    logic [6:0] ticc_num;
    logic [18:0] cv, cond;
    logic [7:0] trap_type;
    logic [2:0] win_save_idx, current_window_pointer;
    logic [2:0] cwp_e = CWP_RST;
    logic sup_e = 1'b1;
    logic fpen_e = 1'b0;
    logic wpend_e = 1'b0;
    int mismatches = 0;
    int samples_checked = 0;
    logic [7:0] tts [16] = '{TT_WRITE_ERR, TT_INST_ACC, TT_PRIV, TT_ILLEGAL,
        TT_FP_DIS, TT_CP_DIS, TT_WATCH, TT_WIN_OVF, TT_WIN_UNF, TT_REG_HW,
        TT_ALIGN, TT_FP_EXC, TT_DATA_ACC, TT_TAG_OVF, TT_DIV_ZERO, TT_SW_BASE};

    assign {fetch_err, priv_op, illegal_op, fp_op, cp_op, save_op,
        restore_op, regfile_err, misaligned, fpu_unimp, fpu_unfinished,
        fpu_seq_err, fpu_hw_err, data_err, tag_ovf, div_zero, ticc_true,
        diag_cache_access, cache_flush_busy} = cond;

    stpu_trap_unit dut (.*);
    stpu_pipe_model pm (.*);

    always #12.5 clk = ~clk;

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] r);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (aw || w) begin
            @(posedge clk);
            if (s_axi_awready) aw = 1'b0;
            if (s_axi_wready) w = 1'b0;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        while (!s_axi_bvalid) @(posedge clk);
        s_axi_bready <= 1'b0;
        check("bresp", 32'(r), 32'(s_axi_bresp));
    endtask

    task automatic axr(logic [7:0] a, logic [31:0] e, logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge clk);
        s_axi_rready <= 1'b0;
        check("rdata", e, s_axi_rdata);
        check("rresp", 32'(r), 32'(s_axi_rresp));
    endtask

    function automatic logic [8:0] exp_tt(logic [18:0] c, logic wm,
        logic [6:0] tn, logic [4:0] ie);
        logic [15:0] r;
        logic [8:0] e;
        r = {c[2], c[3], c[4], c[5] | (c[1] & c[0]),
            fpen_e & c[15] & (ie != 5'h0 || c[9:6] != 4'h0), c[10], c[11],
            c[12], c[13], wm, c[14], c[15] & !fpen_e, c[16], c[17] & !sup_e,
            c[18], wpend_e};
        e = 9'h0;
        for (int i = 15; i >= 0; i--)
            if (r[i]) e = {1'b1, tts[i]};
        if (e[7:0] == TT_SW_BASE) e[6:0] = tn;
        return e;
    endfunction

    task automatic run(logic [18:0] c);
        logic [31:0] da, p;
        logic [6:0] tn;
        logic [4:0] ie;
        logic [8:0] e;
        logic dv;
        da = 32'h1000 + ($urandom & 32'h7);
        dv = 1'($urandom);
        tn = 7'($urandom);
        ie = 5'($urandom) & {5{c[15] & !c[9]}};
        p = $urandom & 32'hFFFF_FFFC;
        e = exp_tt(c, dv && da[31:2] == 30'h400, tn, ie);
        @(posedge clk);
        {data_addr, data_access, ticc_num, fpu_ieee_exc, pc, cv, go}
            <= {da, dv, tn, ie, p, c, 1'b1};
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (!inst_valid);
        #1;
        check("taken", 32'(e[8]), 32'(trap_taken));
        if (e[8]) begin
            cwp_e = cwp_e - 3'h1;
            {sup_e, wpend_e} = 2'h2;
            check("type", 32'(e[7:0]), 32'(trap_type));
            check("target", {20'hA5A55, e[7:0], 4'h0}, trap_target_pc);
            check("save_pc", p, win_save_pc);
            check("cwp", 32'(cwp_e), 32'(current_window_pointer));
            check("sup", 32'h1, 32'(supervisor_bit));
        end
    endtask

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        summarize();
    end

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fetch_addr, data_addr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, go, write_buffer_err, data_access, pc, cv} = '0;
        {fpu_ieee_exc, ticc_num} = '0;
        s_axi_wstrb = 4'hF;
        void'($urandom(39));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check("reset_trap", 32'h3, 32'({trap_taken, trap_is_reset}));
        check("reset_pc", RESET_PC, trap_target_pc);
        check("reset_tt", 32'(TT_RST), 32'(trap_type));
        axr(OFS_CTRL, 32'h1, RESP_OKAY);
        axw(OFS_TBR, 32'hA5A5_5FFF, RESP_OKAY);
        axr(OFS_TBR, 32'hA5A5_5000, RESP_OKAY);
        axw(8'h40, 32'hFFFF_FFFF, RESP_DECERR);
        axr(8'h40, 32'h0, RESP_DECERR);
        axw(OFS_WIM, 32'hFF, RESP_OKAY);
        axw(OFS_WATCH, 32'h1002, RESP_OKAY);
        @(posedge clk);
        write_buffer_err <= 1'b1;
        @(posedge clk);
        write_buffer_err <= 1'b0;
        wpend_e = 1'b1;
        run('1);
        run('1);
        run(19'h3);
        for (int ph = 0; ph < 2; ph++) begin
            for (int i = 0; i < 19; i++) run(19'h1 << i);
            repeat (40) run(19'($urandom));
            axw(OFS_CTRL, 32'h1F02, RESP_OKAY);
            {sup_e, fpen_e} = 2'h1;
            run(19'h20000);
        end
        run(19'h8200);
        axr(OFS_STATUS, {16'h0, TT_FP_EXC, 5'h0, FTT_UNIMP}, RESP_OKAY);
        summarize();
    end
endmodule // stpu_trap_unit_test
